// *** logic/dsc_pkg.sv ***
// package: command codes, field positions, reset values and carrier types
package dsc_pkg;
   // command codes
   localparam logic [7:0] CMD_SW_RESET = 8'h01;
   localparam logic [7:0] CMD_MEM_WRITE = 8'h2c;
   localparam logic [7:0] CMD_SCAN_ORDER = 8'h36;
   localparam logic [7:0] CMD_IDLE_EXIT = 8'h38;
   localparam logic [7:0] CMD_IDLE_ENTER = 8'h39;
   localparam logic [7:0] CMD_PIXEL_FORMAT = 8'h3a;
   // scan order field positions
   localparam int VERT_BIT = 4;
   localparam int CFO_BIT = 3;
   localparam int HORZ_BIT = 2;
   localparam logic [7:0] SCAN_MASK = 8'h1c;
   localparam logic [7:0] SCAN_RESET = 8'h00;
   // pixel format field
   localparam logic [7:0] FMT_MASK = 8'h07;
   localparam logic [7:0] FMT_RESET = 8'h06;
   localparam logic [2:0] FMT_565 = 3'h5;
   localparam logic [2:0] FMT_666 = 3'h6;
   localparam logic [2:0] FMT_888 = 3'h7;
   // frame geometry, columns and pages
   localparam int COORD_W = 9;
   localparam logic [8:0] COL_LAST = 9'h13f;
   localparam logic [8:0] PAGE_LAST = 9'h13f;
   localparam logic [8:0] COORD_ZERO = 9'h000;
   localparam int PIX_W = 6;
   localparam int MSB = 5;
   localparam int N_COMP = 3;

   typedef enum logic [1:0] {
      DSC_ST_IDLE = 2'b00,
      DSC_ST_SCAN = 2'b01,
      DSC_ST_FMT = 2'b10,
      DSC_ST_MEMWR = 2'b11
   } dsc_state_t;

   typedef struct packed {
      logic [PIX_W-1:0] red;
      logic [PIX_W-1:0] green;
      logic [PIX_W-1:0] blue;
   } dsc_pixel_t;

   typedef struct packed {
      logic wrx_s1;
      logic wrx_s2;
      logic wrx_s3;
      logic dcx_s1;
      logic dcx_s2;
      logic [7:0] dat_s1;
      logic [7:0] dat_s2;
      dsc_state_t state;
      logic [7:0] scan_order;
      logic [7:0] pixel_format;
      logic idle_mode;
      logic [COORD_W-1:0] col;
      logic [COORD_W-1:0] page;
      logic [7:0] wr_data;
      logic wr_valid;
      logic wr_first;
      dsc_pixel_t pix;
   } dsc_state_reg_t;
endpackage : dsc_pkg

// *** logic/dsc_cmd_ctrl.sv ***
// command interpreter for scan order, pixel format, idle mode and memory write
// ****************************************************************
// ****************************************************************
`timescale 1ns/1ps
module dsc_cmd_ctrl (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic cmd_param_select_i,
   input wire logic write_strobe_n_i,
   input wire logic read_strobe_n_i,
   input wire logic [7:0] data_i,
   input wire dsc_pkg::dsc_pixel_t pixel_i,
   output dsc_pkg::dsc_pixel_t pixel_o,
   output logic idle_mode_o,
   output logic vertical_refresh_order_o,
   output logic color_filter_order_o,
   output logic horizontal_refresh_order_o,
   output logic [2:0] input_pixel_format_field_o,
   output logic mem_write_active_o,
   output logic [7:0] mem_wr_data_o,
   output logic mem_wr_valid_o,
   output logic mem_wr_first_o,
   output logic [8:0] column_ptr_o,
   output logic [8:0] page_ptr_o
);
   // ****************************************************************
   // reset release
   // ****************************************************************
   logic rst_s1;
   logic rst_n;
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_s1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n <= rst_s1;
      end
   end

   // ****************************************************************
   // state
   // ****************************************************************
   dsc_pkg::dsc_state_reg_t st_r;
   dsc_pkg::dsc_state_reg_t st_nxt;
   logic strobe_rise;
   logic is_cmd;
   logic is_param;
   logic [7:0] byte_in;
   logic [8:0] start_col;
   logic [8:0] start_page;

   // start corner depends on refresh directions
   always_comb begin
      start_col = st_r.scan_order[dsc_pkg::HORZ_BIT] ? dsc_pkg::COL_LAST
                                                     : dsc_pkg::COORD_ZERO;
      start_page = st_r.scan_order[dsc_pkg::VERT_BIT] ? dsc_pkg::PAGE_LAST
                                                      : dsc_pkg::COORD_ZERO;
   end

   // ****************************************************************
   // pixel path
   // ****************************************************************
   logic [dsc_pkg::N_COMP*dsc_pkg::PIX_W-1:0] pix_ordered;
   wire logic [dsc_pkg::N_COMP*dsc_pkg::PIX_W-1:0] pix_shown;

   // colour filter order swaps the outer components
   always_comb begin
      pix_ordered = pixel_i;
      if (st_r.scan_order[dsc_pkg::CFO_BIT]) begin
         pix_ordered = {pixel_i.blue, pixel_i.green, pixel_i.red};
      end
   end

   // idle mode spreads the top bit of each component over all its bits
   for (genvar c = 0; c < dsc_pkg::N_COMP; c++) begin : g_comp
      assign pix_shown[c*dsc_pkg::PIX_W +: dsc_pkg::PIX_W] = st_r.idle_mode
         ? {dsc_pkg::PIX_W{pix_ordered[c*dsc_pkg::PIX_W + dsc_pkg::MSB]}}
         : pix_ordered[c*dsc_pkg::PIX_W +: dsc_pkg::PIX_W];
   end

   always_comb begin
      st_nxt = st_r;
      // select and data pass two flops before use, the strobe three
      st_nxt.wrx_s1 = write_strobe_n_i;
      st_nxt.wrx_s2 = st_r.wrx_s1;
      st_nxt.wrx_s3 = st_r.wrx_s2;
      st_nxt.dcx_s1 = cmd_param_select_i;
      st_nxt.dcx_s2 = st_r.dcx_s1;
      st_nxt.dat_s1 = data_i;
      st_nxt.dat_s2 = st_r.dat_s1;
      st_nxt.pix = pix_shown;
      st_nxt.wr_valid = 1'b0;
      st_nxt.wr_first = 1'b0;
      strobe_rise = st_r.wrx_s2 && !st_r.wrx_s3;
      is_cmd = strobe_rise && !st_r.dcx_s2;
      is_param = strobe_rise && st_r.dcx_s2;
      byte_in = st_r.dat_s2;
      // commands are taken regardless of idle mode
      if (is_cmd) begin
         st_nxt.state = dsc_pkg::DSC_ST_IDLE;
         case (byte_in)
            dsc_pkg::CMD_SW_RESET: begin
               st_nxt.idle_mode = 1'b0;
            end
            dsc_pkg::CMD_IDLE_ENTER: begin
               st_nxt.idle_mode = 1'b1;
            end
            dsc_pkg::CMD_IDLE_EXIT: begin
               st_nxt.idle_mode = 1'b0;
            end
            dsc_pkg::CMD_SCAN_ORDER: begin
               st_nxt.state = dsc_pkg::DSC_ST_SCAN;
            end
            dsc_pkg::CMD_PIXEL_FORMAT: begin
               st_nxt.state = dsc_pkg::DSC_ST_FMT;
            end
            dsc_pkg::CMD_MEM_WRITE: begin
               st_nxt.state = dsc_pkg::DSC_ST_MEMWR;
               st_nxt.col = start_col;
               st_nxt.page = start_page;
               st_nxt.wr_first = 1'b1;
            end
            default: begin
            end
         endcase
      end else if (is_param) begin
         case (st_r.state)
            dsc_pkg::DSC_ST_SCAN: begin
               st_nxt.scan_order = byte_in & dsc_pkg::SCAN_MASK;
               st_nxt.state = dsc_pkg::DSC_ST_IDLE;
            end
            dsc_pkg::DSC_ST_FMT: begin
               st_nxt.pixel_format = byte_in & dsc_pkg::FMT_MASK;
               st_nxt.state = dsc_pkg::DSC_ST_IDLE;
            end
            dsc_pkg::DSC_ST_MEMWR: begin
               // no count limit; stays here until another command
               st_nxt.wr_data = byte_in;
               st_nxt.wr_valid = 1'b1;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         st_r.wrx_s1 <= 1'b1;
         st_r.wrx_s2 <= 1'b1;
         st_r.wrx_s3 <= 1'b1;
         st_r.dcx_s1 <= 1'b0;
         st_r.dcx_s2 <= 1'b0;
         st_r.dat_s1 <= 8'h00;
         st_r.dat_s2 <= 8'h00;
         st_r.state <= dsc_pkg::DSC_ST_IDLE;
         st_r.scan_order <= dsc_pkg::SCAN_RESET;
         st_r.pixel_format <= dsc_pkg::FMT_RESET;
         st_r.idle_mode <= 1'b0;
         st_r.col <= dsc_pkg::COORD_ZERO;
         st_r.page <= dsc_pkg::COORD_ZERO;
         st_r.wr_data <= 8'h00;
         st_r.wr_valid <= 1'b0;
         st_r.wr_first <= 1'b0;
         st_r.pix <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   // frame memory lives outside and is never touched by resets
   assign pixel_o = st_r.pix;

   assign idle_mode_o = st_r.idle_mode;
   assign vertical_refresh_order_o = st_r.scan_order[dsc_pkg::VERT_BIT];
   assign color_filter_order_o = st_r.scan_order[dsc_pkg::CFO_BIT];
   assign horizontal_refresh_order_o = st_r.scan_order[dsc_pkg::HORZ_BIT];
   assign input_pixel_format_field_o = st_r.pixel_format[2:0];
   assign mem_write_active_o = (st_r.state == dsc_pkg::DSC_ST_MEMWR);
   assign mem_wr_data_o = st_r.wr_data;
   assign mem_wr_valid_o = st_r.wr_valid;
   assign mem_wr_first_o = st_r.wr_first;
   assign column_ptr_o = st_r.col;
   assign page_ptr_o = st_r.page;
endmodule : dsc_cmd_ctrl

// *** verif/dsc_host_mdl.sv ***
// host model that drives command and parameter bytes
`timescale 1ns/1ps
module dsc_host_mdl (
   input wire logic core_clk_i,
   output logic cmd_param_select_o,
   output logic write_strobe_n_o,
   output logic [7:0] data_o
);
   initial begin
      cmd_param_select_o = 1'b1;
      write_strobe_n_o = 1'b1;
      data_o = 8'h00;
   end
   // select and data hold well past the rising strobe, then data turns over
   task send(input logic dc, input logic [7:0] b);
      @(posedge core_clk_i);
      cmd_param_select_o <= dc;
      data_o <= b;
      write_strobe_n_o <= 1'b0;
      repeat (4) @(posedge core_clk_i);
      write_strobe_n_o <= 1'b1;
      repeat (6) @(posedge core_clk_i);
      data_o <= ~b;
      #1;
   endtask : send
endmodule : dsc_host_mdl

// *** verif/dsc_cmd_ctrl_chk.sv ***
// port assertions for the command interpreter
`timescale 1ns/1ps
module dsc_cmd_ctrl_chk (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic cmd_param_select_i,
   input wire logic write_strobe_n_i,
   input wire dsc_pkg::dsc_pixel_t pixel_i,
   input wire dsc_pkg::dsc_pixel_t pixel_o,
   input wire logic idle_mode_o,
   input wire logic vertical_refresh_order_o,
   input wire logic color_filter_order_o,
   input wire logic horizontal_refresh_order_o,
   input wire logic [2:0] input_pixel_format_field_o,
   input wire logic mem_write_active_o,
   input wire logic mem_wr_valid_o,
   input wire logic mem_wr_first_o,
   input wire logic [8:0] column_ptr_o,
   input wire logic [8:0] page_ptr_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);
   chk_idle_msb: assert property (idle_mode_o && !color_filter_order_o |=>
      pixel_o == {{6{$past(pixel_i.red[5])}}, {6{$past(pixel_i.green[5])}},
      {6{$past(pixel_i.blue[5])}}}) else $error("idle pixel not reduced");
   chk_bgr_swap: assert property (!idle_mode_o && color_filter_order_o |=>
      pixel_o == {$past(pixel_i.blue), $past(pixel_i.green), $past(pixel_i.red)})
      else $error("bgr swap wrong");
   chk_start_pos: assert property (mem_wr_first_o |-> mem_write_active_o &&
      column_ptr_o == (horizontal_refresh_order_o ? 9'h13f : 9'h000) &&
      page_ptr_o == (vertical_refresh_order_o ? 9'h13f : 9'h000)) else $error("bad start");
   chk_act_first: assert property ($rose(mem_write_active_o) |-> mem_wr_first_o)
      else $error("write began without pointer reset");
   chk_valid_one: assert property (mem_wr_valid_o |-> mem_write_active_o ##1 !mem_wr_valid_o)
      else $error("pixel pulse wrong");
   chk_fmt_param: assert property ($changed(input_pixel_format_field_o) |->
      cmd_param_select_i && write_strobe_n_i) else $error("format changed without parameter");
   chk_scan_param: assert property ($changed({vertical_refresh_order_o,
      color_filter_order_o, horizontal_refresh_order_o}) |-> cmd_param_select_i)
      else $error("scan order changed without parameter");
   chk_idle_cmd: assert property ($changed(idle_mode_o) |-> !cmd_param_select_i)
      else $error("idle changed without command");
   chk_end_cmd: assert property ($fell(mem_write_active_o) |-> !cmd_param_select_i)
      else $error("write ended without command");
endmodule : dsc_cmd_ctrl_chk
bind dsc_cmd_ctrl dsc_cmd_ctrl_chk i_chk (.core_clk_i, .resetn_i, .cmd_param_select_i,
   .write_strobe_n_i, .pixel_i, .pixel_o, .idle_mode_o, .vertical_refresh_order_o,
   .color_filter_order_o, .horizontal_refresh_order_o, .input_pixel_format_field_o,
   .mem_write_active_o, .mem_wr_valid_o, .mem_wr_first_o, .column_ptr_o, .page_ptr_o);

// *** verif/dsc_cmd_ctrl_tb.sv ***
// testbench for the command interpreter
`timescale 1ns/1ps
module dsc_cmd_ctrl_tb;
   logic core_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic read_strobe_n_i = 1'b1;
   logic cmd_param_select_i, write_strobe_n_i, idle_mode_o, vertical_refresh_order_o;
   logic color_filter_order_o, horizontal_refresh_order_o, mem_write_active_o;
   logic mem_wr_valid_o, mem_wr_first_o;
   logic [7:0] data_i, mem_wr_data_o;
   logic [2:0] input_pixel_format_field_o;
   logic [8:0] column_ptr_o, page_ptr_o;
   dsc_pkg::dsc_pixel_t pixel_i = '0;
   dsc_pkg::dsc_pixel_t pixel_o;
   int mismatches = 0;
   int n_checks = 0;
   int nval = 0;
   always #25 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) if (mem_wr_valid_o === 1'b1) nval <= nval + 1;
   dsc_cmd_ctrl i_dut (.core_clk_i, .resetn_i, .cmd_param_select_i, .write_strobe_n_i,
      .read_strobe_n_i, .data_i, .pixel_i, .pixel_o, .idle_mode_o, .vertical_refresh_order_o,
      .color_filter_order_o, .horizontal_refresh_order_o, .input_pixel_format_field_o,
      .mem_write_active_o, .mem_wr_data_o, .mem_wr_valid_o, .mem_wr_first_o, .column_ptr_o,
      .page_ptr_o);
   dsc_host_mdl i_host (.core_clk_i, .cmd_param_select_o(cmd_param_select_i),
      .write_strobe_n_o(write_strobe_n_i), .data_o(data_i));
   // status word: idle, vertical, filter, horizontal, active, format
   function automatic logic [17:0] st();
      return {10'h000, idle_mode_o, vertical_refresh_order_o, color_filter_order_o,
         horizontal_refresh_order_o, mem_write_active_o, input_pixel_format_field_o};
   endfunction : st
   task cmp(input logic [17:0] got, input logic [17:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task cmd(input logic [7:0] b);
      i_host.send(1'b0, b);
   endtask : cmd
   task prm(input logic [7:0] b);
      i_host.send(1'b1, b);
   endtask : prm
   task give_verdict;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : give_verdict
   initial begin
      #100000;
      mismatches++;
      give_verdict;
   end
   initial begin
      pixel_i <= {6'h21, 6'h2a, 6'h1e};
      repeat (12) @(posedge core_clk_i);
      resetn_i <= 1'b1;
      repeat (6) @(posedge core_clk_i);
      #1 cmp(st(), 18'h06);
      for (int i = 0; i < 3; i++) begin
         cmd(8'h36);
         prm(8'he3 | (8'h04 << i));
         cmp(st(), 18'h06 | (18'h10 << i));
      end
      cmd(8'h36);
      prm(8'h08);
      cmp(pixel_o, {6'h1e, 6'h2a, 6'h21});
      cmd(8'h38);
      cmp(st(), 18'h26);
      cmd(8'h39);
      cmp(st(), 18'ha6);
      cmp(pixel_o, {6'h00, 6'h3f, 6'h3f});
      cmd(8'h36);
      prm(8'h00);
      cmp(pixel_o, {6'h3f, 6'h3f, 6'h00});
      cmd(8'h36);
      prm(8'h08);
      for (int f = 5; f < 8; f++) begin
         cmd(8'h3a);
         prm(8'hf8 | 8'(f));
         cmp(st(), 18'ha0 | 18'(f));
      end
      cmd(8'h01);
      cmp(st(), 18'h27);
      cmd(8'h36);
      prm(8'h14);
      cmd(8'h2c);
      cmp(st(), 18'h5f);
      cmp({column_ptr_o, page_ptr_o}, {9'h13f, 9'h13f});
      for (int k = 0; k < 5; k++) begin
         prm(8'(8'h80 + k));
         cmp({10'h000, mem_wr_data_o}, 18'(8'h80 + k));
      end
      cmp(18'(nval), 18'd5);
      cmd(8'h38);
      prm(8'h55);
      cmp(st(), 18'h57);
      cmp(18'(nval), 18'd5);
      cmd(8'h36);
      prm(8'h00);
      cmd(8'h2c);
      cmp({column_ptr_o, page_ptr_o}, 18'h00000);
      prm(8'h12);
      cmp({10'h000, mem_wr_data_o}, 18'h00012);
      @(posedge core_clk_i) resetn_i <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      resetn_i <= 1'b1;
      repeat (6) @(posedge core_clk_i);
      #1 cmp(st(), 18'h06);
      cmd(8'h39);
      cmp(st(), 18'h86);
      give_verdict;
   end
endmodule : dsc_cmd_ctrl_tb
